// ==== logic/dfm_monitor.v ====
// How it works
// - analog, digital, bridge and charge-pump faults in two registers
// - supply fault sets a sticky bit that stays after the fault leaves
// - software clears a fault by writing zero; reset clears all faults
// - open, short-to-ground and short-to-supply share one sticky sensor bit
// - two bits in decimator control select the open-detect pull-down value
// - four chain range points each own one sticky bit, over and under shared
// - cap oscillator out of range sets one sticky bit when enabled
// - software connects two test capacitors to the capacitive front end
// - loop-back enable routes dac one/two into the front end via dividers
// - loop-back forces resistive mode; dac pins keep driving
// - ninth byte of bank five holds crc over banks one to five
// - loading banks one..five in order computes crc and updates error bit
// - trim checked at power-up before processor reset release
// - start bit begins ram self-test; done flag set on finish
// - fail bit reads one for faulty ram, zero otherwise
// - self-test runs only once per power cycle
// - main clock out of window resets whole device when enabled
// - software watchdog resets core without a toggle for 500 ms
// - watchdog reset clears both dac registers, others keep values
// - low-power bits gate bridge, dac two, front end and two clocks
`timescale 1ns/1ns
`include "dfm_regs.vh"
module dfm_monitor #(
    parameter WD_CYC = `DFM_WD_CYC
) (
    input  wire        CORE_CLK_I,
    input  wire        RESET_N_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    input  wire [3:0]  SUPPLY_FAULT_I,
    input  wire [2:0]  SENSOR_FAULT_I,
    input  wire [3:0]  RANGE_FAULT_I,
    input  wire        CAP_OSC_FAULT_I,
    input  wire        MAIN_CLK_FAULT_I,
    input  wire        TRIM_ERR_I,
    input  wire        TRIM_DONE_I,
    input  wire        NVM_LOAD_I,
    input  wire [2:0]  NVM_BANK_I,
    input  wire [3:0]  NVM_INDEX_I,
    input  wire [7:0]  NVM_BYTE_I,
    input  wire [7:0]  RAM_RDATA_I,
    output reg  [7:0]  RAM_ADDR_O,
    output reg  [7:0]  RAM_WDATA_O,
    output reg         RAM_WE_O,
    output reg         RAM_TEST_BUSY_O,
    output reg         CPU_RESET_O,
    output reg         DEVICE_RESET_O,
    output reg  [1:0]  PULLDOWN_SELECT_O,
    output reg  [1:0]  TEST_CAP_EN_O,
    output reg         DAC_LOOPBACK_O,
    output reg         CAP_MODE_O,
    output reg  [11:0] DAC1_O,
    output reg  [11:0] DAC2_O,
    output reg  [4:0]  POWER_GATE_O
);

    // reset release through two flip-flops
    reg rst_s1_r;
    reg rst_s2_r;
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    // only the second stage feeds the logic, so release is clean
    wire rst_n = rst_s2_r;

    // register map, one aligned word each, data in the low bits:
    //   supply a      analog, digital fault flags
    //   supply b      bridge, charge pump fault flags
    //   afe flags     sensor, four range points, cap oscillator
    //   dec ctrl      pulldown a/b, dac two enable, front end enable
    //   enable ctrl   sw watchdog, main watchdog, cap monitor, loop-back
    //   enable ctrl 2 ram self-test start, interface clock, nvm clock
    //   sensor ctrl   bridge enable, capacitive type, test capacitors
    //   nvm status    crc error, trim error
    //   ram status    done, fail
    //   wd service    any write restarts the service window
    //   dac one/two   twelve-bit output codes

    // apb decode; single-cycle access phase
    // writes land at the edge that also samples ready high
    wire acc  = PSEL_I & PENABLE_I;
    wire wr   = acc & PWRITE_I;
    wire [7:0] wd = PWDATA_I[7:0];
    wire hit_sa  = PADDR_I == `DFM_SUPPLY_A;
    wire hit_sb  = PADDR_I == `DFM_SUPPLY_B;
    wire hit_afe = PADDR_I == `DFM_AFE_FLAGS;
    wire hit_dec = PADDR_I == `DFM_DEC_LP_CTRL;
    wire hit_en  = PADDR_I == `DFM_ENCTRL;
    wire hit_en2 = PADDR_I == `DFM_ENCTRL2;
    wire hit_sen = PADDR_I == `DFM_SENSOR_CTRL;
    wire hit_nvm = PADDR_I == `DFM_NVM_STATUS;
    wire hit_ram = PADDR_I == `DFM_RAMST;
    wire hit_wds = PADDR_I == `DFM_WDSERVICE;
    wire hit_d1  = PADDR_I == `DFM_DAC1;
    wire hit_d2  = PADDR_I == `DFM_DAC2;
    wire hit_any = hit_sa | hit_sb | hit_afe | hit_dec | hit_en | hit_en2 |
                   hit_sen | hit_nvm | hit_ram | hit_wds | hit_d1 | hit_d2;

    // sticky fault registers and control registers
    reg [1:0] sup_a_r;   // analog, digital
    reg [1:0] sup_b_r;   // bridge, charge pump
    reg [5:0] afe_r;     // sensor, four range points, cap osc
    reg [3:0] en_r;      // loopback, cap osc mon, main wd, sw wd
    reg [3:0] dec_r;     // pulldown a, pulldown b, second_dac_enable, front_end_enable
    reg [2:0] en2_r;     // ram start, iface clk, nvm clk
    reg [1:0] sen_r;     // bridge en, sensor type (1 = capacitive)
    reg [1:0] tcap_r;
    reg [11:0] dac1_r;
    reg [11:0] dac2_r;
    reg       sw_rst_r;

    wire [5:0] afe_set = {CAP_OSC_FAULT_I & en_r[2], RANGE_FAULT_I,
                          |SENSOR_FAULT_I};

    // latch faults; clear by writing zero or by reset, set wins
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            sup_a_r <= 2'b00;
            sup_b_r <= 2'b00;
            afe_r   <= 6'h00;
        end else begin
            // a fault in the clearing cycle keeps its bit set
            sup_a_r <= SUPPLY_FAULT_I[1:0] |
                       (sup_a_r & ((wr & hit_sa) ? wd[1:0] : 2'b11));
            sup_b_r <= SUPPLY_FAULT_I[3:2] |
                       (sup_b_r & ((wr & hit_sb) ? wd[1:0] : 2'b11));
            afe_r   <= afe_set |
                       (afe_r & ((wr & hit_afe) ? wd[5:0] : 6'h3f));
        end
    end

    // control registers; dac data also cleared by watchdog reset
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            en_r   <= `DFM_ENCTRL_RST;
            dec_r  <= `DFM_DEC_RST;
            en2_r  <= `DFM_EN2_RST;
            sen_r  <= `DFM_SEN_RST;
            tcap_r <= 2'b00;
            dac1_r <= `DFM_DAC_RST;
            dac2_r <= `DFM_DAC_RST;
        end else begin
            if (wr & hit_en)  en_r  <= wd[3:0];
            if (wr & hit_dec) dec_r <= wd[3:0];
            if (wr & hit_en2) en2_r <= wd[2:0];
            if (wr & hit_sen) begin
                sen_r  <= wd[1:0];
                tcap_r <= wd[3:2];
            end
            if (sw_rst_r) begin
                dac1_r <= `DFM_DAC_RST;
                dac2_r <= `DFM_DAC_RST;
            end else begin
                if (wr & hit_d1) dac1_r <= PWDATA_I[11:0];
                if (wr & hit_d2) dac2_r <= PWDATA_I[11:0];
            end
        end
    end

    // crc over banks one..five, sequence tracked bank by bank
    reg [2:0] next_bank_r;
    reg [7:0] crc_r;
    reg       crc_err_r;
    wire      in_seq = NVM_BANK_I == next_bank_r;
    wire      crc_byte = (NVM_BANK_I == `DFM_CRC_BANK) &&
                         (NVM_INDEX_I == `DFM_CRC_INDEX);
    wire      last_load = NVM_LOAD_I & in_seq &
                          (NVM_BANK_I == `DFM_CRC_BANK) & crc_byte;
    // a fresh bank one start out of sequence begins from the seed
    // value, so a partial sum from a load cut off past bank one never leaks into the next check
    wire      restart = !in_seq && NVM_INDEX_I == 4'h0 &&
                        NVM_BANK_I == 3'h1;
    reg [7:0] crc_nxt;
    integer   k;
    always @* begin
        crc_nxt = (restart ? `DFM_CRC_INIT : crc_r) ^ NVM_BYTE_I;
        for (k = 0; k < 8; k = k + 1) begin
            crc_nxt = crc_nxt[7] ? ((crc_nxt << 1) ^ `DFM_CRC_POLY)
                                 : (crc_nxt << 1);
        end
    end
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            next_bank_r <= 3'h1;
            crc_r       <= `DFM_CRC_INIT;
            crc_err_r   <= 1'b0;
        end else if (NVM_LOAD_I) begin
            if (NVM_BANK_I == 3'h0) begin
                crc_r <= crc_r;
            end else if (restart) begin
                next_bank_r <= 3'h1;
                crc_r       <= crc_nxt;
            end else if (in_seq) begin
                if (last_load) begin
                    crc_err_r   <= crc_r != NVM_BYTE_I;
                    next_bank_r <= 3'h1;
                    crc_r       <= `DFM_CRC_INIT;
                end else begin
                    crc_r <= crc_nxt;
                    if (NVM_INDEX_I == `DFM_BANK_END ||
                        (NVM_BANK_I == `DFM_CRC_BANK && 1'b0))
                        next_bank_r <= next_bank_r + 3'h1;
                end
            end
        end
    end

    // trim result captured once at power-up, holds cpu in reset until done
    // later trim strobes are ignored so the power-up verdict stands
    reg trim_err_r;
    reg trim_ok_r;
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            trim_err_r <= 1'b0;
            trim_ok_r  <= 1'b0;
        end else if (TRIM_DONE_I && !trim_ok_r) begin
            trim_err_r <= TRIM_ERR_I;
            trim_ok_r  <= 1'b1;
        end
    end

    // ram self-test: write pattern, read back, once per power cycle
    localparam ST_IDLE  = 2'd0;
    localparam ST_WRITE = 2'd1;
    localparam ST_READ  = 2'd2;
    localparam ST_DONE  = 2'd3;
    reg [1:0] st_r;
    reg [8:0] addr_r;
    reg       ran_r;
    reg       fail_r;
    reg       chk_r;
    // the ram answers one cycle after the address, so the data is
    // compared with the address that was presented one cycle earlier
    reg [7:0] prev_addr_r;
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= ST_IDLE;
            addr_r <= 9'd0;
            ran_r  <= 1'b0;
            fail_r <= 1'b0;
            chk_r  <= 1'b0;
            prev_addr_r <= 8'h00;
        end else begin
            prev_addr_r <= RAM_ADDR_O;
            chk_r <= (st_r == ST_READ) && addr_r != 9'd0;
            if (chk_r && RAM_RDATA_I != ~prev_addr_r)
                fail_r <= 1'b1;
            case (st_r)
                ST_IDLE: begin
                    if (en2_r[0] && !ran_r) begin
                        st_r  <= ST_WRITE;
                        ran_r <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    addr_r <= addr_r + 9'd1;
                    if (addr_r == `DFM_RAM_WORDS - 9'd1) begin
                        addr_r <= 9'd0;
                        st_r   <= ST_READ;
                    end
                end
                ST_READ: begin
                    addr_r <= addr_r + 9'd1;
                    if (addr_r == `DFM_RAM_WORDS)
                        st_r <= ST_DONE;
                end
                ST_DONE:  st_r <= ST_DONE;
                default:  st_r <= ST_IDLE;
            endcase
        end
    end

    // done only once the last read-back compare has landed in fail
    wire ram_done = (st_r == ST_DONE) && !chk_r;

    // software watchdog: toggle write restarts count
    // the toggle itself is never readable; a timeout pulses sw_rst_r
    // for one cycle and the count starts over while still enabled
    reg [31:0] wd_cnt_r;
    reg        tog_r;
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_r <= 32'h0;
            tog_r    <= 1'b0;
            sw_rst_r <= 1'b0;
        end else begin
            sw_rst_r <= 1'b0;
            if (wr & hit_wds) begin
                tog_r    <= ~tog_r;
                wd_cnt_r <= 32'h0;
            end else if (!en_r[0]) begin
                wd_cnt_r <= 32'h0;
            end else if (wd_cnt_r == WD_CYC - 1) begin
                wd_cnt_r <= 32'h0;
                sw_rst_r <= 1'b1;
            end else begin
                wd_cnt_r <= wd_cnt_r + 32'h1;
            end
        end
    end

    // registered outputs
    // every top-level output comes straight from a flip-flop, and
    // read data is taken from the address of the setup cycle
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            PREADY_O          <= 1'b0;
            PSLVERR_O         <= 1'b0;
            PRDATA_O          <= 32'h0;
            RAM_ADDR_O        <= 8'h00;
            RAM_WDATA_O       <= 8'h00;
            RAM_WE_O          <= 1'b0;
            RAM_TEST_BUSY_O   <= 1'b0;
            CPU_RESET_O       <= 1'b1;
            DEVICE_RESET_O    <= 1'b0;
            PULLDOWN_SELECT_O <= 2'b00;
            TEST_CAP_EN_O     <= 2'b00;
            DAC_LOOPBACK_O    <= 1'b0;
            CAP_MODE_O        <= 1'b0;
            DAC1_O            <= `DFM_DAC_RST;
            DAC2_O            <= `DFM_DAC_RST;
            POWER_GATE_O      <= 5'h00;
        end else begin
            PREADY_O  <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & ~hit_any;
            case (PADDR_I)
                `DFM_SUPPLY_A:   PRDATA_O <= {30'h0, sup_a_r};
                `DFM_SUPPLY_B:   PRDATA_O <= {30'h0, sup_b_r};
                `DFM_AFE_FLAGS:  PRDATA_O <= {26'h0, afe_r};
                `DFM_DEC_LP_CTRL: PRDATA_O <= {28'h0, dec_r};
                `DFM_ENCTRL:     PRDATA_O <= {28'h0, en_r};
                `DFM_ENCTRL2:    PRDATA_O <= {29'h0, en2_r};
                `DFM_SENSOR_CTRL: PRDATA_O <= {28'h0, tcap_r, sen_r};
                `DFM_NVM_STATUS: PRDATA_O <= {30'h0, trim_err_r, crc_err_r};
                `DFM_RAMST:      PRDATA_O <= {30'h0, fail_r,
                                              ram_done};
                `DFM_DAC1:       PRDATA_O <= {20'h0, dac1_r};
                `DFM_DAC2:       PRDATA_O <= {20'h0, dac2_r};
                default:         PRDATA_O <= 32'h0;
            endcase
            RAM_ADDR_O      <= addr_r[7:0];
            RAM_WDATA_O     <= ~addr_r[7:0];
            RAM_WE_O        <= st_r == ST_WRITE;
            RAM_TEST_BUSY_O <= st_r == ST_WRITE || st_r == ST_READ;
            CPU_RESET_O     <= ~trim_ok_r | sw_rst_r;
            DEVICE_RESET_O  <= MAIN_CLK_FAULT_I & en_r[1];
            PULLDOWN_SELECT_O <= dec_r[1:0];
            TEST_CAP_EN_O   <= tcap_r;
            DAC_LOOPBACK_O  <= en_r[3];
            CAP_MODE_O      <= sen_r[1] & ~en_r[3];
            DAC1_O          <= dac1_r;
            DAC2_O          <= dac2_r;
            POWER_GATE_O    <= {en2_r[2], en2_r[1], dec_r[3],
                                dec_r[2], sen_r[0]};
        end
    end

endmodule // dfm_monitor

// ==== logic/dfm_regs.vh ====
`ifndef DFM_REGS_VH
`define DFM_REGS_VH
// register byte offsets
`define DFM_SUPPLY_A      12'h000
`define DFM_SUPPLY_B      12'h004
`define DFM_AFE_FLAGS     12'h008
`define DFM_DEC_LP_CTRL   12'h00c
`define DFM_ENCTRL        12'h010
`define DFM_ENCTRL2       12'h014
`define DFM_SENSOR_CTRL   12'h018
`define DFM_NVM_STATUS    12'h01c
`define DFM_RAMST         12'h020
`define DFM_WDSERVICE     12'h024
`define DFM_DAC1          12'h028
`define DFM_DAC2          12'h02c
`define DFM_NVM_BANK      12'h030
// field widths and reset values
`define DFM_DAC_W         12
`define DFM_DAC_RST       12'h000
`define DFM_ENCTRL_RST    4'h0
`define DFM_DEC_RST       4'h0
`define DFM_EN2_RST       3'h6
`define DFM_SEN_RST       2'h1
// nvm bank / crc
`define DFM_CRC_BANK      3'h5
`define DFM_CRC_POLY      8'h07
`define DFM_CRC_INIT      8'h00
`define DFM_CRC_INDEX     4'h8
`define DFM_BANK_END      4'hf
// ram self-test walk length
`define DFM_RAM_WORDS     9'd256
// timing: clock 10 MHz, service window 500 ms
`define DFM_CLK_HZ        10000000
`define DFM_WD_MS         500
`define DFM_WD_CYC        (`DFM_CLK_HZ / 1000 * `DFM_WD_MS)
`endif

// ==== verification/dfm_monitor_properties.sv ====
`timescale 1ns/1ns
module dfm_mon_props #(
    parameter WD_CYC = 50
) (
    input wire        CORE_CLK_I, RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PRDATA_O,
    input wire        PREADY_O, PSLVERR_O, MAIN_CLK_FAULT_I, TRIM_DONE_I,
    input wire        CPU_RESET_O, DEVICE_RESET_O, RAM_WE_O,
    input wire        RAM_TEST_BUSY_O, DAC_LOOPBACK_O, CAP_MODE_O,
    input wire [11:0] DAC1_O, DAC2_O
);
    localparam int WD_MIN = WD_CYC - 2;
    reg [31:0] since_r;
    reg        trim_r;
    // cycles since the last service write; trim completion seen
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            since_r <= 32'h0;
            trim_r <= 1'b0;
        end else begin
            if (TRIM_DONE_I)
                trim_r <= 1'b1;
            if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 12'h024)
                since_r <= 32'h0;
            else if (since_r != 32'hffffffff)
                since_r <= since_r + 32'h1;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_setup; PSEL_I && !PENABLE_I; endsequence
    sequence s_run; RAM_TEST_BUSY_O [*8]; endsequence
    chk_ready_access: assert property (s_setup |=> PREADY_O)
        else $error("no ready in access phase");
    chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    chk_err_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 0)
        else $error("refused read not zero");
    chk_loop_resistive: assert property (DAC_LOOPBACK_O |-> !CAP_MODE_O)
        else $error("capacitive mode during loop-back");
    chk_main_wd_cause: assert property (DEVICE_RESET_O |-> $past(MAIN_CLK_FAULT_I))
        else $error("device reset without clock fault");
    chk_wd_not_early: assert property ($rose(CPU_RESET_O) |-> since_r >= WD_MIN)
        else $error("core reset before service window ends");
    chk_wd_dac_zero: assert property ($fell(CPU_RESET_O) |-> ##[0:2]
        (DAC1_O == 12'h000 && DAC2_O == 12'h000))
        else $error("dac not cleared by core reset");
    chk_trim_first: assert property ($fell(CPU_RESET_O) |-> trim_r)
        else $error("core released before trim check");
    chk_ram_we_busy: assert property (RAM_WE_O |-> RAM_TEST_BUSY_O)
        else $error("ram write outside self-test");
    chk_ram_run_len: assert property ($rose(RAM_TEST_BUSY_O) |->
        s_run ##[1:600] !RAM_TEST_BUSY_O)
        else $error("self-test length wrong");
endmodule // dfm_mon_props

bind dfm_monitor dfm_mon_props #(.WD_CYC(WD_CYC)) u_props (
    .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .MAIN_CLK_FAULT_I(MAIN_CLK_FAULT_I), .TRIM_DONE_I(TRIM_DONE_I),
    .CPU_RESET_O(CPU_RESET_O), .DEVICE_RESET_O(DEVICE_RESET_O),
    .RAM_WE_O(RAM_WE_O), .RAM_TEST_BUSY_O(RAM_TEST_BUSY_O),
    .DAC_LOOPBACK_O(DAC_LOOPBACK_O), .CAP_MODE_O(CAP_MODE_O),
    .DAC1_O(DAC1_O), .DAC2_O(DAC2_O));

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, q, seed = 3;
    logic [3:0] sup = 0, rng = 0;
    logic [2:0] sen = 0;
    logic cap = 0, mclk = 0, terr = 0, tdone = 0, nld = 0, bad_ram = 0;
    logic [2:0] nbk = 0;
    logic [3:0] nix = 0;
    logic [7:0] nby = 0;
    logic [7:0] rrd = 0, mem [0:255];
    wire [31:0] prd;
    wire prdy, perr, rwe, rbusy, cpur, devr, lb, cmode;
    wire [7:0] radr, rwd;
    wire [1:0] pds, tcap;
    wire [11:0] d1, d2;
    wire [4:0] pg;
    integer miscompares = 0, tests_run = 0, mdl [0:11], i, k, n;
    dfm_monitor #(.WD_CYC(50)) u_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .SUPPLY_FAULT_I(sup), .SENSOR_FAULT_I(sen), .RANGE_FAULT_I(rng),
        .CAP_OSC_FAULT_I(cap), .MAIN_CLK_FAULT_I(mclk), .TRIM_ERR_I(terr),
        .TRIM_DONE_I(tdone), .NVM_LOAD_I(nld), .NVM_BANK_I(nbk),
        .NVM_INDEX_I(nix), .NVM_BYTE_I(nby), .RAM_RDATA_I(rrd),
        .RAM_ADDR_O(radr), .RAM_WDATA_O(rwd), .RAM_WE_O(rwe),
        .RAM_TEST_BUSY_O(rbusy), .CPU_RESET_O(cpur), .DEVICE_RESET_O(devr),
        .PULLDOWN_SELECT_O(pds), .TEST_CAP_EN_O(tcap), .DAC_LOOPBACK_O(lb),
        .CAP_MODE_O(cmode), .DAC1_O(d1), .DAC2_O(d2), .POWER_GATE_O(pg));
    // clock and a synchronous-read ram beside the self-test port
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (rwe)
            mem[radr] <= rwd ^ {7'h00, bad_ram & (radr == 8'h5a)};
        rrd <= mem[radr];
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    // crc-8, polynomial 0x07, one byte at a time
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        integer b;
        crc8 = c ^ d;
        for (b = 0; b < 8; b++)
            crc8 = crc8[7] ? {crc8[6:0], 1'b0} ^ 8'h07 : {crc8[6:0], 1'b0};
    endfunction
    // bank zero byte, then banks one to five in order; crc good or spoiled
    task automatic nvm(input logic bad);
        logic [7:0] c;
        integer b, x;
        c = 0;
        @(posedge clk);
        nld <= 1; nbk <= 0; nix <= 0; nby <= 8'h3c;
        for (b = 1; b < 6; b++)
            for (x = 0; x < 16; x++)
                if (b < 5 || x < 9) begin
                    @(posedge clk);
                    seed = xs(seed);
                    nbk <= b; nix <= x;
                    nby <= (b == 5 && x == 8) ? c ^ bad : seed[7:0];
                    if (b < 5 || x < 8)
                        c = crc8(c, seed[7:0]);
                end
        @(posedge clk);
        nld <= 0;
        repeat (2) @(posedge clk);
        mdl[7][0] = bad;
    endtask
    task automatic mdl_init;
        for (i = 0; i < 12; i++)
            mdl[i] = 0;
        mdl[5] = 6;
        mdl[6] = 1;
    endtask
    // start the self-test and poll its status until done
    task automatic ram_run(input logic [31:0] want);
        wr(12'h014, mdl[5] | 1);
        q = 0;
        n = 0;
        while (q[0] !== 1'b1) begin
            if (n > 300) begin
                miscompares++;
                report_and_stop;
            end
            apb(0, 12'h020, 0);
            n++;
        end
        mdl[8] = want;
        chk(q, want);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("compared %0d, mismatched %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer, waiting a bounded time for ready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        integer t;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        t = 0;
        @(posedge clk);
        while (prdy !== 1'b1) begin
            t++;
            if (t > 20) begin
                miscompares++;
                report_and_stop;
            end
            @(posedge clk);
        end
        q = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    // write with model update: fault regs keep ones, others store
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
        i = a >> 2;
        if (i < 3)
            mdl[i] = mdl[i] & d;
        else
            mdl[i] = d & ((i > 9) ? 32'hfff : (i == 5) ? 32'h7 : 32'hf);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(0, a, 0);
        chk(q, mdl[a >> 2]);
    endtask
    // hold fault inputs for two cycles and latch them in the model
    task automatic flt(input logic [3:0] s, input logic [2:0] f,
                       input logic [3:0] r, input logic c);
        sup <= s; sen <= f; rng <= r; cap <= c;
        repeat (2) @(posedge clk);
        sup <= 0; sen <= 0; rng <= 0; cap <= 0;
        @(posedge clk);
        mdl[0] |= s[1:0];
        mdl[1] |= s[3:2];
        mdl[2] |= {c & mdl[4][2], r, |f};
    endtask
    initial begin
        mdl_init;
        repeat (20) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        chk(cpur, 1);
        terr <= 1;
        tdone <= 1;
        @(posedge clk);
        tdone <= 0;
        repeat (3) @(posedge clk);
        chk(cpur, 0);
        mdl[7] = 2;
        for (k = 0; k < 12; k++)
            if (k != 9) rd(k * 4);
        apb(1, 12'h040, 5);
        chk(e, 1);
        apb(0, 12'h040, 0);
        chk(e, 1);
        chk(q, 0);
        $display("test reset and map done");
        nvm(0);
        rd(12'h01c);
        nvm(1);
        rd(12'h01c);
        $display("test nvm crc done");
        for (k = 0; k < 8; k++) begin
            if (k == 4) wr(12'h010, 4);
            seed = xs(seed);
            flt(seed[3:0], seed[6:4], seed[10:7], seed[11]);
            rd(0); rd(4); rd(8);
            wr(0, seed[13:12]); wr(4, seed[15:14]); wr(8, seed[21:16]);
            rd(0); rd(4); rd(8);
        end
        sup <= 1;
        repeat (2) @(posedge clk);
        wr(0, 0);
        mdl[0] = 1;
        rd(0);
        sup <= 0;
        wr(0, 0);
        rd(0);
        $display("test fault latching done");
        seed = xs(seed);
        wr(12'h018, seed[3:0] | 2); wr(12'h00c, seed[7:4]);
        wr(12'h014, {seed[9:8], 1'b0});
        wr(12'h028, seed[11:0]); wr(12'h02c, seed[23:12]);
        repeat (2) @(posedge clk);
        chk(tcap, mdl[6][3:2]);
        chk(pds, mdl[3][1:0]);
        chk(pg, {mdl[5][2:1], mdl[3][3:2], mdl[6][0]});
        chk(cmode, 1);
        chk({d2, d1}, {mdl[11][11:0], mdl[10][11:0]});
        wr(12'h010, 8);
        repeat (2) @(posedge clk);
        chk({lb, cmode}, 2'b10);
        chk({d2, d1}, {mdl[11][11:0], mdl[10][11:0]});
        rd(12'h018);
        $display("test control outputs done");
        wr(12'h010, 1);
        for (k = 0; k < 4; k++) begin
            repeat (20) @(posedge clk);
            wr(12'h024, k);
            chk(cpur, 0);
        end
        n = 0;
        while (cpur !== 1'b1) begin
            if (n > 200) begin
                miscompares++;
                report_and_stop;
            end
            @(posedge clk);
            n++;
        end
        chk(n > 40 && n < 60, 1);
        repeat (3) @(posedge clk);
        mdl[10] = 0;
        mdl[11] = 0;
        chk({d2, d1}, 0);
        rd(12'h028); rd(12'h02c); rd(12'h010); rd(12'h018);
        wr(12'h010, 0);
        $display("test software watchdog done");
        ram_run(1);
        wr(12'h014, 6); wr(12'h014, 7);
        repeat (4) @(posedge clk);
        chk(rbusy, 0);
        rd(12'h020);
        $display("test ram self-test done");
        mclk <= 1;
        repeat (3) @(posedge clk);
        chk(devr, 0);
        wr(12'h010, 2);
        repeat (2) @(posedge clk);
        chk(devr, 1);
        mclk <= 0;
        repeat (3) @(posedge clk);
        $display("test clock watchdog done");
        flt(4'hf, 3'h7, 4'hf, 0);
        bad_ram <= 1;
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        mdl_init;
        chk(cpur, 1);
        rd(0); rd(4); rd(8);
        ram_run(3);
        $display("test reset rerun done");
        report_and_stop;
    end
endmodule // testbench
